// *** design/twc_params.svh ***
// Purpose: Offsets, field positions, reset values and timing for the controller
// Assumes: 100 MHz system clock
// Notes: Register index times four gives the Wishbone byte address
`ifndef TWC_PARAMS_SVH
`define TWC_PARAMS_SVH
// Register indices
`define TWC_IDX_TIMING 4'h0
`define TWC_IDX_DEBUG 4'h2
`define TWC_IDX_CTLA 4'h3
`define TWC_IDX_CMD 4'h4
`define TWC_IDX_STAT 4'h5
`define TWC_IDX_ADDR 4'h7
`define TWC_IDX_DATA 4'h8
// Field positions
`define TWC_F_SETUP 4
`define TWC_F_HOLD 2
`define TWC_F_FMP 1
`define TWC_F_RUN_IN_DEBUG 0
`define TWC_F_READ_IRQ_ENABLE 7
`define TWC_F_WRITE_IRQ_ENABLE 6
`define TWC_F_QUICK_COMMAND_ENABLE 4
`define TWC_F_TMO 2
`define TWC_F_AUTO_ACK_ENABLE 1
`define TWC_F_EN 0
`define TWC_F_FLUSH 3
`define TWC_F_ACK 2
// Reset value of every register
`define TWC_RST 8'h00
// Command codes
`define TWC_CMD_NONE 2'h0
`define TWC_CMD_RSTART 2'h1
`define TWC_CMD_XFER 2'h2
`define TWC_CMD_STOP 2'h3
// Timing
`define TWC_CLK_MHZ 100
`define TWC_SETUP_SHORT 4
`define TWC_SETUP_LONG 8
`define TWC_HOLD1_NS 50
`define TWC_HOLD2_NS 300
`define TWC_HOLD3_NS 500
`define TWC_HALF_STD_NS 5000
`define TWC_HALF_FMP_NS 500
`define TWC_TMO_US 50
`endif

// *** design/twc_pkg.sv ***
// Purpose: Types shared by the two-wire controller
// Assumes: Classic Wishbone, 32-bit data
// Notes: Constants live in twc_params.svh
package twc_pkg;
  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [5:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } twc_wb_req_t;
  // Wishbone answer
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } twc_wb_rsp_t;
  // Pin levels seen on the wires
  typedef struct packed {
    logic scl_in;
    logic sda_in;
  } twc_pin_in_t;
  // Pin drive, enables active low
  typedef struct packed {
    logic scl_out;
    logic scl_oe_n;
    logic sda_out;
    logic sda_oe_n;
  } twc_pin_out_t;
  // Bus state field codes
  typedef enum logic [1:0] {
    BS_UNKNOWN = 2'h0,
    BS_IDLE = 2'h1,
    BS_OWNER = 2'h2,
    BS_BUSY = 2'h3
  } twc_bus_t;
  // Engine states
  typedef enum logic [3:0] {
    S_IDLE, S_WAIT, S_START, S_LOW, S_HIGH, S_HOLD, S_RS, S_RS2, S_STOP_A, S_STOP_B
  } twc_state_t;
  // Kind of bit group being clocked
  typedef enum logic [1:0] {K_ADDR, K_WR, K_RD, K_ACK} twc_kind_t;
  // What follows a lone acknowledge bit
  typedef enum logic [1:0] {A_HOLD, A_RS, A_STOP} twc_after_t;
  // Shift set-up for one bit group
  typedef struct packed {
    logic [8:0] sh;
    logic [8:0] chk;
    logic [3:0] bits;
  } twc_shift_t;
endpackage

// *** design/twc_ctrl.sv ***
// Purpose: Two-wire bus controller control, command and status logic
// Assumes: Pins pass two flops; link clock sampled at 100 MHz
// Notes: Registers sit in bits 7:0 of aligned Wishbone words
// How it works
// - Data setup 4 or 8 cycles
// - Hold select: off, 50, 300, 500 ns
// - Fast-plus bit selects 1 MHz speed
// - Debug-run low halts during CPU break
// - Read irq needs enable, flag, global
// - Write irq needs enable, flag, global
// - Quick command flags right after address ack
// - Idle timeout off, 50, 100, 200 us
// - Smart mode acks on data read
// - Enable bit turns controller on
// - Flush strobe clears engine, address, data
// - Ack action bit: 0 ack, 1 nack
// - Command bits are strobes reading zero
// - Commands: none, restart, transfer, stop
// - Ack action and command in one write
// - Address writes, data accesses and commands other than none clear flags
// - Read flag only on clean acked read
// - Data read or odd address starts read
// - Writing one clears read flag
// - Address write clears all flags
// - Write flag set even on error
// - Bus state codes; writing idle forces idle
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "twc_params.svh"

module twc_ctrl
  import twc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `TWC_TMO_US * `TWC_CLK_MHZ,
  parameter int unsigned HALF_STD_CYC = `TWC_HALF_STD_NS * `TWC_CLK_MHZ / 1000,
  parameter int unsigned HALF_FMP_CYC = `TWC_HALF_FMP_NS * `TWC_CLK_MHZ / 1000
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // CPU side
  input wire logic debug_halt,
  input wire logic global_irq_enable,
  output logic read_irq,
  output logic write_irq,
  // Register bus
  input wire twc_wb_req_t wb_req,
  output twc_wb_rsp_t wb_rsp,
  // Two-wire pins
  input wire twc_pin_in_t pin_in,
  output twc_pin_out_t pin_out
);
  // Refuse counts the 16-bit timers cannot hold
  if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 16383 || HALF_FMP_CYC < 1
      || HALF_STD_CYC > 65535 || HALF_FMP_CYC > HALF_STD_CYC) begin : g_bad
    $error("twc_ctrl: timing parameters out of range");
  end

  // Derived cycle counts, least times rounded up
  localparam logic [15:0] HOLD1 = 16'((`TWC_HOLD1_NS * `TWC_CLK_MHZ + 999) / 1000);
  localparam logic [15:0] HOLD2 = 16'((`TWC_HOLD2_NS * `TWC_CLK_MHZ + 999) / 1000);
  localparam logic [15:0] HOLD3 = 16'((`TWC_HOLD3_NS * `TWC_CLK_MHZ + 999) / 1000);
  localparam logic [15:0] HSTD = 16'(HALF_STD_CYC);
  localparam logic [15:0] HFMP = 16'(HALF_FMP_CYC);
  localparam logic [15:0] TMO = 16'(TIMEOUT_CYC);

  // Configuration bits
  logic setup_sel;
  logic [1:0] hold_sel;
  logic fast_plus_enable;
  logic run_in_debug;
  logic read_irq_enable;
  logic write_irq_enable;
  logic quick_command_enable;
  logic [1:0] timeout_sel;
  logic auto_ack_enable;
  logic ctrl_enable;
  logic ack_action;

  // Engine and status state
  twc_state_t state;
  twc_kind_t kind;
  twc_after_t after;
  twc_bus_t bus_state_field;
  logic [15:0] cnt;
  logic [8:0] sh, chk, rx;
  logic [3:0] bits;
  logic scl_rel, sda_rel;
  logic [7:0] target_address_reg;
  logic [7:0] controller_data_reg;
  logic read_done_flag, write_done_flag, scl_hold_flag;
  logic arbitration_lost_flag, bus_error_flag, rx_ack;
  logic last_read;

  // Pin synchronisers and edge history
  logic [1:0] scl_sy, sda_sy;
  logic scl_s, sda_s, scl_p, sda_p;
  logic start_det, stop_det;

  // Bus slave
  logic ack_q;
  logic acc, wr, rd;
  logic [3:0] idx;
  logic [7:0] wdat, rword;
  logic wr_timing, wr_debug, wr_ctla, wr_cmd, wr_stat, wr_addr, wr_data, rd_data;
  logic flush_stb, clr_all, cmd_ack, run;

  // Timing selections and idle timer
  logic [15:0] half_cyc, hold_cyc, setup_cyc, low_end, tmo_lim, tmo_cnt;
  logic tmo_hit;

  // Wishbone decode, effects land on the ack edge
  assign acc = wb_req.cyc & wb_req.stb & ~ack_q;
  assign idx = wb_req.adr[5:2];
  assign wr = acc & wb_req.we & wb_req.sel[0];
  assign rd = acc & ~wb_req.we;
  assign wdat = wb_req.dat[7:0];
  assign wr_timing = wr && idx == `TWC_IDX_TIMING;
  assign wr_debug = wr && idx == `TWC_IDX_DEBUG;
  assign wr_ctla = wr && idx == `TWC_IDX_CTLA;
  assign wr_cmd = wr && idx == `TWC_IDX_CMD;
  assign wr_stat = wr && idx == `TWC_IDX_STAT;
  assign wr_addr = wr && idx == `TWC_IDX_ADDR;
  assign wr_data = wr && idx == `TWC_IDX_DATA;
  assign rd_data = rd && idx == `TWC_IDX_DATA;
  // One-cycle flush strobe
  assign flush_stb = wr_cmd & wdat[`TWC_F_FLUSH];
  // Accesses that clear the controller flags
  assign clr_all = wr_addr | wr_data | rd_data
                 | (wr_cmd && wdat[1:0] != `TWC_CMD_NONE);
  // Ack value from the same write wins
  assign cmd_ack = wr_cmd ? wdat[`TWC_F_ACK] : ack_action;
  // Engine halts in break unless allowed
  assign run = ~(debug_halt & ~run_in_debug);

  // Timing selections
  assign half_cyc = fast_plus_enable ? HFMP : HSTD;
  assign setup_cyc = setup_sel ? 16'(`TWC_SETUP_LONG) : 16'(`TWC_SETUP_SHORT);
  always_comb begin
    // Hold time choice
    case (hold_sel)
      2'h1: hold_cyc = HOLD1;
      2'h2: hold_cyc = HOLD2;
      2'h3: hold_cyc = HOLD3;
      default: hold_cyc = 16'h0000;
    endcase
    // Low phase lasts long enough for hold plus setup
    low_end = (hold_cyc + setup_cyc > half_cyc) ? hold_cyc + setup_cyc : half_cyc;
    // Timeout limit doubles per step
    case (timeout_sel)
      2'h2: tmo_lim = {TMO[14:0], 1'b0};
      2'h3: tmo_lim = {TMO[13:0], 2'b00};
      default: tmo_lim = TMO;
    endcase
  end

  // Start and stop seen on the wires
  assign start_det = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_det = scl_s & scl_p & ~sda_p & sda_s;
  assign tmo_hit = timeout_sel != 2'h0 && tmo_cnt == tmo_lim - 16'h0001;

  // Interrupt requests
  assign read_irq = read_irq_enable & read_done_flag & global_irq_enable;
  assign write_irq = write_irq_enable & write_done_flag & global_irq_enable;

  // Open-drain pins: drive low only
  assign pin_out.scl_out = 1'b0;
  assign pin_out.sda_out = 1'b0;
  assign pin_out.scl_oe_n = scl_rel;
  assign pin_out.sda_oe_n = sda_rel;

  // Build the shift set-up for a bit group
  function automatic twc_shift_t load(input twc_kind_t k, input logic [7:0] b,
                                      input logic a);
    twc_shift_t s;
    s = '{sh: 9'h000, chk: 9'h000, bits: 4'h0};
    case (k)
      K_ADDR, K_WR: s = '{sh: {b, 1'b1}, chk: 9'h1fe, bits: 4'h9};
      K_RD: s = '{sh: {a, 8'hff}, chk: 9'h100, bits: 4'h9};
      K_ACK: s = '{sh: {a, 8'h00}, chk: 9'h100, bits: 4'h1};
      default: s = '{sh: 9'h000, chk: 9'h000, bits: 4'h0};
    endcase
    return s;
  endfunction

  // Register read mux, unused bits zero
  always_comb begin
    case (idx)
      `TWC_IDX_TIMING: rword = {3'h0, setup_sel, hold_sel, fast_plus_enable, 1'b0};
      `TWC_IDX_DEBUG: rword = {7'h00, run_in_debug};
      `TWC_IDX_CTLA: rword = {read_irq_enable, write_irq_enable, 1'b0,
                              quick_command_enable, timeout_sel, auto_ack_enable,
                              ctrl_enable};
      `TWC_IDX_CMD: rword = {5'h00, ack_action, 2'b00};
      `TWC_IDX_STAT: rword = {read_done_flag, write_done_flag, scl_hold_flag, rx_ack,
                              arbitration_lost_flag, bus_error_flag, bus_state_field};
      `TWC_IDX_ADDR: rword = target_address_reg;
      `TWC_IDX_DATA: rword = controller_data_reg;
      default: rword = 8'h00;
    endcase
  end

  // Wishbone answer, one wait state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
      wb_rsp <= '{ack: 1'b0, dat: 32'h0000_0000};
    end else if (clk_en) begin
      ack_q <= acc;
      wb_rsp.ack <= acc;
      // Read data captured with the ack
      if (rd)
        wb_rsp.dat <= {24'h00_0000, rword};
    end
  end

  // Two-flop pin synchronisers, then history
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sy <= 2'b11;
      sda_sy <= 2'b11;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else if (clk_en) begin
      scl_sy <= {scl_sy[0], pin_in.scl_in};
      sda_sy <= {sda_sy[0], pin_in.sda_in};
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end
  assign scl_s = scl_sy[1];
  assign sda_s = sda_sy[1];

  // Configuration registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      {setup_sel, hold_sel, fast_plus_enable} <= 4'h0;
      run_in_debug <= 1'b0;
      {read_irq_enable, write_irq_enable, quick_command_enable} <= 3'h0;
      {timeout_sel, auto_ack_enable, ctrl_enable, ack_action} <= 5'h00;
    end else if (clk_en) begin
      // Timing selections
      if (wr_timing) begin
        setup_sel <= wdat[`TWC_F_SETUP];
        hold_sel <= wdat[`TWC_F_HOLD +: 2];
        fast_plus_enable <= wdat[`TWC_F_FMP];
      end
      // Debug run
      if (wr_debug)
        run_in_debug <= wdat[`TWC_F_RUN_IN_DEBUG];
      // Controller control
      if (wr_ctla) begin
        read_irq_enable <= wdat[`TWC_F_READ_IRQ_ENABLE];
        write_irq_enable <= wdat[`TWC_F_WRITE_IRQ_ENABLE];
        quick_command_enable <= wdat[`TWC_F_QUICK_COMMAND_ENABLE];
        timeout_sel <= wdat[`TWC_F_TMO +: 2];
        auto_ack_enable <= wdat[`TWC_F_AUTO_ACK_ENABLE];
        ctrl_enable <= wdat[`TWC_F_EN];
      end
      // Plain read/write ack bit
      if (wr_cmd)
        ack_action <= wdat[`TWC_F_ACK];
    end
  end

  // Idle timer: lines high while busy
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      tmo_cnt <= 16'h0000;
    else if (clk_en) begin
      if (bus_state_field == BS_BUSY && scl_s && sda_s && !tmo_hit && run)
        tmo_cnt <= tmo_cnt + 16'h0001;
      else if (run)
        tmo_cnt <= 16'h0000;
    end
  end

  // Controller engine, flags and data path
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      kind <= K_ADDR;
      after <= A_HOLD;
      bus_state_field <= BS_UNKNOWN;
      cnt <= 16'h0000;
      {sh, chk, rx, bits} <= 31'h0;
      scl_rel <= 1'b1;
      sda_rel <= 1'b1;
      target_address_reg <= `TWC_RST;
      controller_data_reg <= `TWC_RST;
      {read_done_flag, write_done_flag, scl_hold_flag} <= 3'h0;
      {arbitration_lost_flag, bus_error_flag, rx_ack, last_read} <= 4'h0;
    end else if (clk_en) begin
      // Software clears first so hardware sets win
      if (clr_all) begin
        {read_done_flag, write_done_flag, scl_hold_flag} <= 3'h0;
        {arbitration_lost_flag, bus_error_flag} <= 2'h0;
      end
      // Write-one-to-clear status bits
      if (wr_stat) begin
        if (wdat[7]) read_done_flag <= 1'b0;
        if (wdat[6]) write_done_flag <= 1'b0;
        if (wdat[5]) scl_hold_flag <= 1'b0;
        if (wdat[3]) arbitration_lost_flag <= 1'b0;
        if (wdat[2]) bus_error_flag <= 1'b0;
        if (wdat[1:0] == BS_IDLE) bus_state_field <= BS_IDLE;
      end
      if (wr_addr) target_address_reg <= wdat;
      if (wr_data) controller_data_reg <= wdat;
      // Disabled or flushed: engine, pins and bus state back to rest
      if (!ctrl_enable || flush_stb) begin
        state <= S_IDLE;
        scl_rel <= 1'b1;
        sda_rel <= 1'b1;
        bus_state_field <= BS_UNKNOWN;
        last_read <= 1'b0;
        if (flush_stb) begin
          target_address_reg <= `TWC_RST;
          controller_data_reg <= `TWC_RST;
        end
      end else if (run) begin
        // Bus monitor while not driving a frame
        if (tmo_hit) bus_state_field <= BS_IDLE;
        if (state == S_IDLE || state == S_WAIT) begin
          if (start_det) bus_state_field <= BS_BUSY;
          if (stop_det) bus_state_field <= BS_IDLE;
        end
        // Foreign start or stop mid-byte
        if ((state == S_LOW || state == S_HIGH) && (start_det || stop_det)) begin
          bus_error_flag <= 1'b1;
          write_done_flag <= 1'b1;
          state <= S_IDLE;
          scl_rel <= 1'b1;
          sda_rel <= 1'b1;
          bus_state_field <= BS_BUSY;
        end else begin
          case (state)
            // Address write opens a frame
            S_IDLE: begin
              if (wr_addr) begin
                cnt <= 16'h0000;
                if (bus_state_field == BS_UNKNOWN) begin
                  write_done_flag <= 1'b1;
                  bus_error_flag <= 1'b1;
                end else if (bus_state_field == BS_IDLE)
                  state <= S_START;
                else
                  state <= S_WAIT;
              end
            end
            // Wait for a free bus
            S_WAIT: begin
              if (bus_state_field == BS_IDLE) begin
                state <= S_START;
                cnt <= 16'h0000;
              end
            end
            // Start: data low while clock high
            S_START: begin
              sda_rel <= 1'b0;
              bus_state_field <= BS_OWNER;
              cnt <= cnt + 16'h0001;
              if (cnt == half_cyc - 16'h0001) begin
                {sh, chk, bits} <= load(K_ADDR, target_address_reg, 1'b0);
                kind <= K_ADDR;
                scl_rel <= 1'b0;
                state <= S_LOW;
                cnt <= 16'h0000;
              end
            end
            // Clock low: hold, then data, then setup
            S_LOW: begin
              cnt <= cnt + 16'h0001;
              if (cnt == hold_cyc)
                sda_rel <= sh[8];
              if (cnt == low_end - 16'h0001) begin
                scl_rel <= 1'b1;
                state <= S_HIGH;
                cnt <= 16'h0000;
              end
            end
            // Clock high, stretched by the target
            S_HIGH: begin
              if (scl_s)
                cnt <= cnt + 16'h0001;
              if (scl_s && cnt == half_cyc - 16'h0001) begin
                rx <= {rx[7:0], sda_s};
                sh <= {sh[7:0], 1'b0};
                chk <= {chk[7:0], 1'b0};
                bits <= bits - 4'h1;
                cnt <= 16'h0000;
                scl_rel <= 1'b0;
                if (chk[8] && sh[8] && !sda_s) begin
                  arbitration_lost_flag <= 1'b1;
                  write_done_flag <= 1'b1;
                  state <= S_IDLE;
                  scl_rel <= 1'b1;
                  sda_rel <= 1'b1;
                  bus_state_field <= BS_BUSY;
                end else if (bits != 4'h1)
                  state <= S_LOW;
                else begin
                  state <= S_HOLD;
                  case (kind)
                    // Address byte done
                    K_ADDR: begin
                      rx_ack <= sda_s;
                      last_read <= 1'b0;
                      if (target_address_reg[0] && !sda_s) begin
                        if (quick_command_enable) begin
                          read_done_flag <= 1'b1;
                          scl_hold_flag <= 1'b1;
                        end else begin
                          {sh, chk, bits} <= load(K_RD, 8'h00, 1'b1);
                          sh <= 9'h1fe;
                          chk <= 9'h000;
                          bits <= 4'h8;
                          kind <= K_RD;
                          state <= S_LOW;
                        end
                      end else begin
                        write_done_flag <= 1'b1;
                        scl_hold_flag <= 1'b1;
                      end
                    end
                    // Written byte done
                    K_WR: begin
                      rx_ack <= sda_s;
                      write_done_flag <= 1'b1;
                      scl_hold_flag <= 1'b1;
                    end
                    // Read byte done cleanly
                    K_RD: begin
                      controller_data_reg <= {rx[6:0], sda_s};
                      read_done_flag <= 1'b1;
                      scl_hold_flag <= 1'b1;
                      last_read <= 1'b1;
                    end
                    // Lone ack bit: go on
                    default: begin
                      last_read <= 1'b0;
                      if (after == A_HOLD) scl_hold_flag <= 1'b1;
                      if (after == A_RS) state <= S_RS;
                      if (after == A_STOP) state <= S_STOP_A;
                    end
                  endcase
                end
              end
            end
            // Clock held low awaiting software
            S_HOLD: begin
              cnt <= 16'h0000;
              if (wr_addr || (wr_cmd && wdat[1:0] == `TWC_CMD_RSTART)) begin
                state <= last_read ? S_LOW : S_RS;
                {sh, chk, bits} <= load(K_ACK, 8'h00, cmd_ack);
                kind <= K_ACK;
                after <= A_RS;
              end else if (wr_cmd && wdat[1:0] == `TWC_CMD_STOP) begin
                state <= last_read ? S_LOW : S_STOP_A;
                {sh, chk, bits} <= load(K_ACK, 8'h00, cmd_ack);
                kind <= K_ACK;
                after <= A_STOP;
              end else if ((wr_cmd && wdat[1:0] == `TWC_CMD_XFER && target_address_reg[0])
                  || (rd_data && last_read && auto_ack_enable && !ack_action)) begin
                state <= S_LOW;
                {sh, chk, bits} <= load(K_RD, 8'h00, cmd_ack);
                kind <= K_RD;
              end else if ((wr_cmd && wdat[1:0] == `TWC_CMD_XFER) || (wr_data && !last_read)) begin
                state <= S_LOW;
                {sh, chk, bits} <= load(K_WR, wr_data ? wdat : controller_data_reg, 1'b0);
                kind <= K_WR;
              end
            end
            // Repeated start: release data, then clock
            S_RS: begin
              sda_rel <= 1'b1;
              cnt <= cnt + 16'h0001;
              if (cnt == half_cyc - 16'h0001) begin
                scl_rel <= 1'b1;
                state <= S_RS2;
                cnt <= 16'h0000;
              end
            end
            S_RS2: begin
              if (scl_s) cnt <= cnt + 16'h0001;
              if (scl_s && cnt == half_cyc - 16'h0001) begin
                state <= S_START;
                cnt <= 16'h0000;
              end
            end
            // Stop: data low, clock up, data up
            S_STOP_A: begin
              sda_rel <= 1'b0;
              cnt <= cnt + 16'h0001;
              if (cnt == half_cyc - 16'h0001) begin
                scl_rel <= 1'b1;
                state <= S_STOP_B;
                cnt <= 16'h0000;
              end
            end
            S_STOP_B: begin
              if (scl_s) cnt <= cnt + 16'h0001;
              if (scl_s && cnt == half_cyc - 16'h0001) begin
                sda_rel <= 1'b1;
                state <= S_IDLE;
                bus_state_field <= BS_IDLE;
              end
            end
            default: state <= S_IDLE;
          endcase
        end
      end
    end
  end
endmodule // twc_ctrl

// *** dv/twc_target_model.sv ***
// Purpose: Ack-only target
// Assumes: Bench resolves wires
// Notes: SDA released outside ack
`timescale 1ns/10ps
module twc_target_model (
  // Wires
  input wire logic scl,
  input wire logic sda,
  // Drive, low pulls
  output logic sda_oe_n
);
  int falls; // Falls since start
  initial begin
    sda_oe_n = 1'b1;
    falls = 0;
  end
  // Start restarts count
  always @(negedge sda) if (scl) falls = 0;
  // Ack on ninth clock only
  always @(negedge scl) begin
    falls = falls + 1;
    sda_oe_n = (falls != 9);
  end
endmodule // twc_target_model

// *** dv/twc_ctrl_props.sv ***
// Purpose: Port checks
// Assumes: Bus write lands as ack rises
// Notes: Shadows control a
`timescale 1ns/10ps
module twc_ctrl_props
  import twc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic global_irq_enable,
  input wire logic read_irq,
  input wire logic write_irq,
  input wire twc_wb_req_t wb_req,
  input wire twc_wb_rsp_t wb_rsp,
  input wire twc_pin_out_t pin_out
);
  logic [7:0] ctla; // Control a shadow
  // Track control a writes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) ctla <= 8'h00;
    else if (clk_en && wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0] && !wb_rsp.ack
      && wb_req.adr[5:2] == 4'h3) ctla <= wb_req.dat[7:0];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence req_s;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack && clk_en;
  endsequence
  sequence rd_s;
    wb_rsp.ack && !wb_req.we;
  endsequence
  ack_follows_a: assert property (req_s |=> wb_rsp.ack) else $error("no ack");
  ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("long ack");
  upper_zero_a: assert property (rd_s |-> wb_rsp.dat[31:8] == 24'h0)
    else $error("upper bits set");
  cmd_reads_a: assert property (rd_s and wb_req.adr[5:2] == 4'h4 |->
    (wb_rsp.dat[7:0] & 8'hfb) == 8'h00) else $error("cmd bits read");
  hole_reads_a: assert property (rd_s and wb_req.adr[5:2] inside {1, 6, [9:15]} |->
    wb_rsp.dat == 32'h0) else $error("hole read");
  read_gate_a: assert property (read_irq |-> ctla[7] && global_irq_enable)
    else $error("read irq");
  write_gate_a: assert property (write_irq |-> ctla[6] && global_irq_enable)
    else $error("write irq");
  off_quiet_a: assert property (!ctla[0] [*3] |-> pin_out.scl_oe_n && pin_out.sda_oe_n)
    else $error("pins driven");
endmodule // twc_ctrl_props
bind twc_ctrl twc_ctrl_props props_u (.sys_clk, .reset_n, .clk_en, .global_irq_enable,
  .read_irq, .write_irq, .wb_req, .wb_rsp, .pin_out);

// *** dv/tb.sv ***
// Purpose: Controller bench
// Assumes: Short half period
// Notes: Pull-ups on both wires
`timescale 1ns/10ps
module tb;
  import twc_pkg::*;
  logic sys_clk, reset_n, clk_en, debug_halt, global_irq_enable, read_irq, write_irq, t_oe_n;
  twc_wb_req_t wb_req;
  twc_wb_rsp_t wb_rsp;
  twc_pin_in_t pin_in;
  twc_pin_out_t pin_out;
  int miscompares, check_count, seed, i;
  logic [7:0] rd, v;
  assign pin_in = {pin_out.scl_oe_n, pin_out.sda_oe_n & t_oe_n};
  twc_ctrl #(.TIMEOUT_CYC(20), .HALF_STD_CYC(20), .HALF_FMP_CYC(10)) dut_u (.sys_clk,
    .reset_n, .clk_en, .debug_halt, .global_irq_enable, .read_irq, .write_irq, .wb_req,
    .wb_rsp, .pin_in, .pin_out);
  twc_target_model tgt_u (.scl(pin_in.scl_in), .sda(pin_in.sda_in), .sda_oe_n(t_oe_n));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task finish_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle, read data to rd
  task wb(input logic we, input logic [3:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    wb_req <= '{1'b1, 1'b1, we, {idx, 2'h0}, 4'h1, {24'h0, d}};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_rsp.ack !== 1'b1 && n < 50);
    rd = wb_rsp.dat[7:0];
    wb_req <= '0;
    @(posedge sys_clk);
    if (n >= 50) begin
      miscompares++;
      finish_test;
    end
  endtask
  // Poll status until it matches
  task poll(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      wb(1'b0, 4'h5, 8'h00);
      n++;
    end while (rd !== exp && n < 1000);
    chk(rd, exp);
  endtask
  initial begin
    seed = 84238;
    miscompares = 0;
    check_count = 0;
    {reset_n, clk_en, debug_halt, global_irq_enable, wb_req} = {4'b0100, 45'h0};
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 16; i++) begin
      wb(1'b0, i[3:0], 8'h00);
      chk(rd, 8'h00);
    end
    for (i = 0; i < 12; i++) begin
      v = (i == 0) ? 8'hff : 8'($random(seed));
      wb(1'b1, 4'h0, v);
      wb(1'b0, 4'h0, 8'h00);
      chk(rd, v & 8'h1e);
      wb(1'b1, 4'h2, v);
      wb(1'b0, 4'h2, 8'h00);
      chk(rd, v & 8'h01);
      wb(1'b1, 4'h4, v);
      wb(1'b0, 4'h4, 8'h00);
      chk(rd, v & 8'h04);
    end
    $display("test registers done");
    global_irq_enable <= 1'b1;
    wb(1'b1, 4'h3, 8'hc1);
    wb(1'b1, 4'h7, 8'ha0);
    wb(1'b0, 4'h5, 8'h00);
    chk(rd, 8'h44);
    chk({7'h0, write_irq}, 8'h01);
    global_irq_enable <= 1'b0;
    @(posedge sys_clk);
    chk({7'h0, write_irq}, 8'h00);
    global_irq_enable <= 1'b1;
    wb(1'b1, 4'h5, 8'h01);
    poll(8'h45);
    wb(1'b1, 4'h7, 8'ha0);
    poll(8'h62);
    wb(1'b1, 4'h4, 8'h03);
    poll(8'h01);
    $display("test write done");
    wb(1'b1, 4'h3, 8'hd1);
    wb(1'b1, 4'h7, 8'ha1);
    poll(8'ha2);
    chk({7'h0, read_irq}, 8'h01);
    wb(1'b1, 4'h5, 8'h80);
    poll(8'h22);
    wb(1'b1, 4'h4, 8'h03);
    poll(8'h01);
    // Full read: no quick command, smart ack on data read
    wb(1'b1, 4'h3, 8'hc3);
    wb(1'b1, 4'h7, 8'ha1);
    poll(8'ha2);
    wb(1'b0, 4'h8, 8'h00);
    chk(rd, 8'hff);
    poll(8'ha2);
    wb(1'b1, 4'h4, 8'h07);
    poll(8'h01);
    wb(1'b1, 4'h4, 8'h08);
    wb(1'b0, 4'h7, 8'h00);
    chk(rd, 8'h00);
    $display("test read done");
    finish_test;
  end
endmodule // tb
